// [wdt_timing_consts.vh]
// Constants for the watchdog period timing core: register offsets, field
// positions, reset values and prescaler ratios.
// Assumes inclusion by bare name from the design files of this block.
`ifndef WDT_TIMING_CONSTS_VH
`define WDT_TIMING_CONSTS_VH

// Avalon word offsets (byte address = 4 * index).
`define OFS_CONTROL        4'h0
`define OFS_RELOAD         4'h1
`define OFS_STATUS         4'h2
`define OFS_COUNTER        4'h3
`define OFS_EVENT          4'h4

// Control register fields.
`define CTL_LOCK_BIT       0
`define CTL_RATE_REQ_BIT   1
`define CTL_SERVICE_BIT    2
`define CTL_DISABLE_BIT    3

// Status register fields.
`define ST_RATE_BIT        0
`define ST_TIMEOUT_BIT     1
`define ST_PREWARN_BIT     2
`define ST_DISABLED_BIT    3
`define ST_OVF_ERR_BIT     4
`define ST_ACC_ERR_BIT     5

// Event register fields.
`define EV_NMI_BIT         0

// Reset and fixed values.
`define FIXED_START        16'hfffc
`define RELOAD_RESET       16'hfffc
`define WAKE_FROM          16'h7fff

// Prescaler ratios: fast = 256, slow = 256 * 64.
`define DIV_FAST           256
`define DIV_SLOW_MULT      64
`define DIV_SLOW           16384
`define DIV_WIDTH          14

`endif

// [wdt_prescaler.v]
// Free running clock divider giving one-cycle ticks at two ratios.
// Assumes one clock mclk and a synchronous active low reset.
`timescale 1ns/1ps
`include "wdt_timing_consts.vh"

module wdt_prescaler #(
  parameter WIDTH    = `DIV_WIDTH,
  parameter DIV_FAST = `DIV_FAST,
  parameter DIV_SLOW = `DIV_SLOW
) (
  input  wire mclk,        // System clock.
  input  wire rst_b,       // Synchronous reset, active low.
  input  wire rate_fast,   // 1 selects the fast ratio.
  output reg  tick         // One-cycle increment pulse.
);

  reg  [WIDTH-1:0] div_reg;
  wire [WIDTH-1:0] fast_mask = DIV_FAST[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1};
  wire [WIDTH-1:0] slow_mask = DIV_SLOW[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1};

  // Never cleared on mode changes, only by reset.
  always @(posedge mclk) begin
    if (!rst_b) begin
      div_reg <= {WIDTH{1'b0}};
      tick    <= 1'b0;
    end else begin
      div_reg <= div_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      tick    <= rate_fast ? ((div_reg & fast_mask) == fast_mask)
                           : (div_reg == slow_mask);
    end
  end

endmodule // wdt_prescaler

// [wdt_counter.v]
// Sixteen-bit watchdog up-counter with load, tick and event decode.
// Assumes tick pulses come from the shared prescaler.
`timescale 1ns/1ps
`include "wdt_timing_consts.vh"

module wdt_counter #(
  parameter WIDTH = 16
) (
  input  wire             mclk,       // System clock.
  input  wire             rst_b,      // Synchronous reset, active low.
  input  wire             load,       // Load start value this cycle.
  input  wire [WIDTH-1:0] load_value, // Start value.
  input  wire             run,        // Counting allowed.
  input  wire             tick,       // Prescaler tick.
  output reg  [WIDTH-1:0] count,      // Counter value.
  output wire             overflow,   // Wrap this cycle.
  output wire             wake        // Bit 15 rises this cycle.
);

  wire step = run && tick && !load;
  assign overflow = step && (count == {WIDTH{1'b1}});
  assign wake     = step && (count == `WAKE_FROM);

  always @(posedge mclk) begin
    if (!rst_b) begin
      count <= `FIXED_START;
    end else if (load) begin
      count <= load_value;
    end else if (step) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule // wdt_counter

// [wdt_period_timing.v]
// Watchdog period timing core with an Avalon-MM register slave.
// Assumes mclk at 200 MHz, synchronous active low rst_b, and that the
// surrounding reset logic raises soft_reset_event for software resets.
//
// What this block does
// - Prescaler gives sysclk over 256 or 16384.
// - Rate bit 1 selects 256, 0 selects 16384.
// - Period is ticks to wrap times ratio.
// - Start FFFC in time-out, reload in normal.
// - Prescaler not synchronised to mode changes.
// - Reset clears rate bit, loads FFFC.
// - Rate request copied only on proper lock exit.
// - Time-out entry loads FFFC, ends at overflow.
// - Prewarning lasts one time-out period.
// - Normal service enters time-out at FFFC; lock exit to normal reloads full 16-bit value.
// - Counter bit 15 gives sleep wake-up request.
// - Soft reset clears error flags, watchdog reset keeps.
// - Overflow FFFF to 0000 ends normal/time-out/prewarning.
// - 7FFF to 8000 raises wake NMI, no error.
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`include "wdt_timing_consts.vh"

module wdt_period_timing #(
  parameter WIDTH = 16
) (
  input  wire        mclk,             // System clock, 200 MHz.
  input  wire        rst_b,            // Synchronous reset, active low.
  input  wire        soft_reset_event, // Reset was a software reset.
  input  wire        wdt_reset_event,  // Reset was caused by the watchdog.
  input  wire        access_error,     // Pulse: bad access from protocol.
  input  wire        cpu_sleeping,     // CPU idles or sleeps.
  input  wire [3:0]  avs_address,      // Word address.
  input  wire        avs_read,         // Read request.
  input  wire        avs_write,        // Write request.
  input  wire [31:0] avs_writedata,    // Write data.
  input  wire [3:0]  avs_byteenable,   // Byte lanes.
  output reg  [31:0] avs_readdata,     // Read data.
  output reg         avs_waitrequest,  // Stall until answer.
  output reg         wake_nmi,         // Wake-up NMI pulse.
  output reg         system_reset_req, // Pulse at prewarning end.
  output reg         prewarn_nmi       // Pulse at prewarning entry.
);

  // ---------------------------------------------------------------------
  // Mode state
  // ---------------------------------------------------------------------
  localparam [3:0] ST_TIMEOUT  = 4'b0001;
  localparam [3:0] ST_NORMAL   = 4'b0010;
  localparam [3:0] ST_PREWARN  = 4'b0100;
  localparam [3:0] ST_DISABLED = 4'b1000;

  reg [3:0]        state_reg;
  reg [3:0]        state_next;
  reg              rate_select_active;
  reg              rate_select_request;
  reg              init_end_lock;
  reg              disable_request;
  reg [WIDTH-1:0]  reload_value;
  reg              from_timeout_reg;
  reg              ovf_err_reg;
  reg              acc_err_reg;
  reg              nmi_source_flag;
  reg              load_reg;
  reg [WIDTH-1:0]  load_value_reg;
  reg              ack_pending;

  wire             tick;
  wire [WIDTH-1:0] counter_value;
  wire             overflow;
  wire             wake;

  // ---------------------------------------------------------------------
  // Prescaler and counter
  // ---------------------------------------------------------------------
  wdt_prescaler u_prescaler (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .rate_fast (rate_select_active),
    .tick      (tick)
  );

  wdt_counter #(.WIDTH(WIDTH)) u_counter (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .load       (load_reg),
    .load_value (load_value_reg),
    .run        (state_reg != ST_DISABLED),
    .tick       (tick),
    .count      (counter_value),
    .overflow   (overflow),
    .wake       (wake)
  );

  // ---------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------
  // A write lands only at the edge where the master sees waitrequest low.
  wire bus_req = (avs_read || avs_write) && !ack_pending;
  wire wr_take = avs_write && ack_pending;
  wire wr_ctl  = wr_take && (avs_address == `OFS_CONTROL)
                 && avs_byteenable[0];
  wire wr_rel  = wr_take && (avs_address == `OFS_RELOAD);
  wire wr_evt  = wr_take && (avs_address == `OFS_EVENT)
                 && avs_byteenable[0];
  wire svc     = wr_ctl && avs_writedata[`CTL_SERVICE_BIT];
  wire lock_wr = wr_ctl && avs_writedata[`CTL_LOCK_BIT];
  wire can_cfg = (state_reg != ST_PREWARN);

  // Service opens the time-out window; a lock write then leaves it.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_TIMEOUT: begin
        if (overflow)
          state_next = ST_PREWARN;
        else if (access_error)
          state_next = ST_PREWARN;
        else if (lock_wr)
          state_next = disable_request ? ST_DISABLED : ST_NORMAL;
      end
      ST_NORMAL: begin
        if (overflow || access_error)
          state_next = ST_PREWARN;
        else if (svc)
          state_next = ST_TIMEOUT;
      end
      ST_DISABLED: begin
        if (access_error)
          state_next = ST_PREWARN;
        else if (svc)
          state_next = ST_TIMEOUT;
      end
      ST_PREWARN: begin
        state_next = ST_PREWARN;
      end
      default: state_next = ST_TIMEOUT;
    endcase
  end

  // ---------------------------------------------------------------------
  // Control and status registers
  // ---------------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rst_b) begin
      state_reg           <= ST_TIMEOUT;
      rate_select_active  <= 1'b0;
      rate_select_request <= 1'b0;
      init_end_lock       <= 1'b0;
      disable_request     <= 1'b0;
      reload_value        <= `RELOAD_RESET;
      from_timeout_reg    <= 1'b0;
      nmi_source_flag     <= 1'b0;
      load_reg            <= 1'b0;
      load_value_reg      <= `FIXED_START;
      wake_nmi            <= 1'b0;
      prewarn_nmi         <= 1'b0;
      system_reset_req    <= 1'b0;
    end else begin
      state_reg        <= state_next;
      load_reg         <= 1'b0;
      wake_nmi         <= 1'b0;
      prewarn_nmi      <= 1'b0;
      system_reset_req <= 1'b0;
      if (wr_ctl && can_cfg) begin
        rate_select_request <= avs_writedata[`CTL_RATE_REQ_BIT];
        disable_request     <= avs_writedata[`CTL_DISABLE_BIT];
        init_end_lock       <= avs_writedata[`CTL_LOCK_BIT];
      end
      if (wr_rel && avs_byteenable[0])
        reload_value[7:0] <= avs_writedata[7:0];
      if (wr_rel && avs_byteenable[1])
        reload_value[15:8] <= avs_writedata[15:8];
      if (state_reg == ST_TIMEOUT && state_next != ST_TIMEOUT
          && state_next != ST_PREWARN)
        rate_select_active <= rate_select_request;
      if (state_next == ST_TIMEOUT && state_reg != ST_TIMEOUT) begin
        load_reg       <= 1'b1;
        load_value_reg <= `FIXED_START;
      end else if (state_next == ST_NORMAL && state_reg != ST_NORMAL) begin
        load_reg       <= 1'b1;
        load_value_reg <= reload_value;
      end else if (state_next == ST_PREWARN && state_reg != ST_PREWARN) begin
        load_reg         <= 1'b1;
        load_value_reg   <= `FIXED_START;
        prewarn_nmi      <= 1'b1;
        from_timeout_reg <= (state_reg == ST_TIMEOUT);
      end
      if (state_reg == ST_PREWARN && overflow)
        system_reset_req <= 1'b1;
      if (wake && state_reg == ST_NORMAL && cpu_sleeping)
        wake_nmi <= 1'b1;
      if ((wake && state_reg == ST_NORMAL && cpu_sleeping) || prewarn_nmi)
        nmi_source_flag <= 1'b1;
      else if (wr_evt && avs_writedata[`EV_NMI_BIT])
        nmi_source_flag <= 1'b0;
    end
  end

  // Error flags survive a watchdog reset and clear on any other reset.
  always @(posedge mclk) begin
    if (!rst_b) begin
      if (!wdt_reset_event || soft_reset_event) begin
        ovf_err_reg <= 1'b0;
        acc_err_reg <= 1'b0;
      end
    end else begin
      if (overflow && state_reg != ST_PREWARN)
        ovf_err_reg <= 1'b1;
      else if (state_next == ST_NORMAL && state_reg == ST_TIMEOUT)
        ovf_err_reg <= 1'b0;
      if (access_error)
        acc_err_reg <= 1'b1;
      else if (state_next == ST_NORMAL && state_reg == ST_TIMEOUT)
        acc_err_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Avalon answer: one wait cycle, data on the second cycle
  // ---------------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rst_b) begin
      ack_pending     <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      ack_pending     <= bus_req;
      avs_waitrequest <= !bus_req;
      if (bus_req && avs_read) begin
        case (avs_address)
          `OFS_CONTROL: avs_readdata <= {28'h0000000, disable_request,
                                         1'b0, rate_select_request,
                                         init_end_lock};
          `OFS_RELOAD:  avs_readdata <= {16'h0000, reload_value};
          `OFS_STATUS:  avs_readdata <= {26'h0000000, acc_err_reg,
                                         ovf_err_reg,
                                         (state_reg == ST_DISABLED),
                                         (state_reg == ST_PREWARN),
                                         (state_reg == ST_TIMEOUT) ||
                                         (state_reg == ST_PREWARN &&
                                          from_timeout_reg),
                                         rate_select_active};
          `OFS_COUNTER: avs_readdata <= {16'h0000, counter_value};
          `OFS_EVENT:   avs_readdata <= {31'h00000000, nmi_source_flag};
          default:      avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // wdt_period_timing

// [wdt_period_timing_chk.sv]
// Checker for the watchdog timing core: bus answer timing, event pulses, wake gating.
// Assumes it is bound to wdt_period_timing and sees only that module's ports.
`timescale 1ns/1ps

module wdt_period_timing_chk (
  input wire        mclk,             // System clock.
  input wire        rst_b,            // Synchronous reset, active low.
  input wire        cpu_sleeping,     // CPU idles or sleeps.
  input wire [3:0]  avs_address,      // Word address.
  input wire        avs_read,         // Read request.
  input wire        avs_write,        // Write request.
  input wire [31:0] avs_readdata,     // Read data.
  input wire        avs_waitrequest,  // Stall.
  input wire        wake_nmi,         // Wake pulse.
  input wire        system_reset_req, // Reset pulse.
  input wire        prewarn_nmi       // Prewarning pulse.
);
  // ----------------------------------------------------------------
  // Cycles since prewarning entry, saturating when none is pending.
  // ----------------------------------------------------------------
  logic [16:0] gap_reg;

  always_ff @(posedge mclk) begin
    if (!rst_b) gap_reg <= 17'h1ffff;
    else if (prewarn_nmi) gap_reg <= 17'h00000;
    else if (gap_reg != 17'h1ffff) gap_reg <= gap_reg + 17'h00001;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not one cycle after request");
  a_answer_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_idle_wait: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 4'h4
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_data_stands: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without read");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b
    |=> avs_waitrequest && !prewarn_nmi && !system_reset_req)
    else $error("outputs active in reset");
  a_prewarn_pulse: assert property (prewarn_nmi |=> !prewarn_nmi)
    else $error("prewarning pulse too long");
  a_sysreset_pulse: assert property (system_reset_req |=> !system_reset_req)
    else $error("system reset pulse too long");
  a_prewarn_span: assert property (system_reset_req
    |-> gap_reg >= 17'd760 && gap_reg <= 17'd65560)
    else $error("prewarning span out of range");
  a_wake_sleep: assert property (wake_nmi |-> $past(cpu_sleeping) && !$past(wake_nmi))
    else $error("wake pulse without sleep");
endmodule // wdt_period_timing_chk

bind wdt_period_timing wdt_period_timing_chk wdt_period_timing_chk_inst (.mclk(mclk),
  .rst_b(rst_b), .cpu_sleeping(cpu_sleeping), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .wake_nmi(wake_nmi), .system_reset_req(system_reset_req), .prewarn_nmi(prewarn_nmi));

// [wdt_period_timing_tb_top.sv]
// Self-checking bench for the watchdog timing core over its Avalon-MM slave.
// Assumes the register map of the shared constants header and the bound checker.
`timescale 1ns/1ps
`include "wdt_timing_consts.vh"
`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin err_total++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module wdt_period_timing_tb_top;
  logic        mclk, rst_b, soft_ev, wdt_ev, acc_err, sleeping, rd_en, wr_en;
  logic [3:0]  addr;
  logic [31:0] wdata, e_m, m_m;
  logic [31:0] exp_q[$], mask_q[$];
  logic [15:0] rl;
  wire  [31:0] rdata;
  wire         waitreq, wake, sysrst, prewarn;
  int          err_total = 0;
  int          total_checks = 0;

  wdt_period_timing wdt_period_timing_inst (.mclk(mclk), .rst_b(rst_b),
    .soft_reset_event(soft_ev), .wdt_reset_event(wdt_ev), .access_error(acc_err),
    .cpu_sleeping(sleeping), .avs_address(addr), .avs_read(rd_en), .avs_write(wr_en),
    .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .wake_nmi(wake), .system_reset_req(sysrst), .prewarn_nmi(prewarn));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic fail_out();
    err_total++;
    $display("MISMATCH wait expected done seen timeout");
    final_report();
  endtask

  // One bus cycle; a read notes its expected masked data for the monitor.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    int n;
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    rd_en <= !w;
    wr_en <= w;
    if (!w) begin
      exp_q.push_back(d & m);
      mask_q.push_back(m);
    end
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (waitreq === 1'b0) break;
    end
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    if (n == 50) fail_out();
  endtask

  // Waits for a pulse (0 prewarning, 1 system reset, 2 wake) and checks its delay.
  task automatic pulse(input int which, input int lo, input int hi);
    int n;
    for (n = 0; n < hi + 20; n++) begin
      @(posedge mclk);
      if ((which == 0 ? prewarn : which == 1 ? sysrst : wake) === 1'b1) break;
    end
    if (n >= hi + 20) fail_out();
    `CHK("pulse delay", 1'b1, n >= lo && n <= hi)
  endtask

  task automatic do_reset(input logic s, input logic w);
    @(posedge mclk);
    rst_b <= 1'b0;
    soft_ev <= s;
    wdt_ev <= w;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    soft_ev <= 1'b0;
    wdt_ev <= 1'b0;
  endtask

  always @(posedge mclk) begin
    if (rd_en === 1'b1 && waitreq === 1'b0) begin
      if (exp_q.size() == 0) `CHK("read queue", 1'b1, 1'b0)
      else begin
        e_m = exp_q.pop_front();
        m_m = mask_q.pop_front();
        `CHK("readdata", e_m, rdata & m_m)
      end
    end
  end

  initial begin
    {rst_b, soft_ev, wdt_ev, acc_err, sleeping, rd_en, wr_en, addr, wdata} = '0;
    void'($urandom(45181));
    do_reset(1'b0, 1'b0);
    bus(1'b0, `OFS_STATUS, 32'h2, 32'h3f);
    bus(1'b0, `OFS_COUNTER, 32'hfffc, 32'hfffe);
    bus(1'b0, `OFS_RELOAD, 32'hfffc, 32'hffff);
    bus(1'b0, 4'h7, 32'h0, 32'hffffffff);
    bus(1'b1, `OFS_CONTROL, 32'h2, 32'h0);
    bus(1'b0, `OFS_STATUS, 32'h2, 32'h3f);
    $display("test reset_values done");
    rl = 16'hfff0 | 16'($urandom % 13);
    bus(1'b1, `OFS_RELOAD, {16'h0, rl}, 32'h0);
    bus(1'b1, `OFS_CONTROL, 32'h3, 32'h0);
    bus(1'b0, `OFS_STATUS, 32'h1, 32'h3f);
    pulse(0, (32'h10000 - rl - 1) * 256 - 16, (32'h10000 - rl) * 256 + 16);
    bus(1'b0, `OFS_STATUS, 32'h15, 32'h3f);
    bus(1'b0, `OFS_EVENT, 32'h1, 32'h1);
    pulse(1, 3 * 256 - 16, 4 * 256 + 16);
    $display("test normal_period done");
    do_reset(1'b0, 1'b1);
    bus(1'b0, `OFS_STATUS, 32'h12, 32'h3f);
    do_reset(1'b1, 1'b0);
    bus(1'b0, `OFS_STATUS, 32'h2, 32'h3f);
    $display("test reset_flags done");
    bus(1'b1, `OFS_CONTROL, 32'ha, 32'h0);
    bus(1'b1, `OFS_CONTROL, 32'hb, 32'h0);
    bus(1'b0, `OFS_STATUS, 32'h9, 32'h3f);
    repeat (1200) @(posedge mclk);
    bus(1'b0, `OFS_COUNTER, 32'hfffc, 32'hfffe);
    bus(1'b1, `OFS_CONTROL, 32'h4, 32'h0);
    bus(1'b0, `OFS_COUNTER, 32'hfffc, 32'hfffe);
    bus(1'b0, `OFS_STATUS, 32'h3, 32'h3f);
    pulse(0, 3 * 256 - 16, 4 * 256 + 16);
    $display("test disable_service done");
    do_reset(1'b1, 1'b0);
    acc_err <= 1'b1;
    @(posedge mclk);
    acc_err <= 1'b0;
    pulse(0, 0, 4);
    bus(1'b0, `OFS_STATUS, 32'h26, 32'h3f);
    $display("test access_error done");
    do_reset(1'b1, 1'b0);
    sleeping <= 1'b1;
    bus(1'b1, `OFS_RELOAD, 32'h7ff0, 32'h0);
    bus(1'b1, `OFS_CONTROL, 32'h2, 32'h0);
    bus(1'b1, `OFS_CONTROL, 32'h3, 32'h0);
    pulse(2, 15 * 256 - 16, 16 * 256 + 16);
    bus(1'b0, `OFS_STATUS, 32'h1, 32'h3f);
    bus(1'b0, `OFS_EVENT, 32'h1, 32'h1);
    bus(1'b1, `OFS_EVENT, 32'h1, 32'h0);
    bus(1'b0, `OFS_EVENT, 32'h0, 32'h1);
    $display("test wake_up done");
    final_report();
  end
endmodule // wdt_period_timing_tb_top
